//--- core/tm2_pkg.sv
/*
 * Constants for the third timer/counter block: register offsets,
 * control bit positions, reset values and machine-cycle counts.
 * Assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
 */
// Operation
// [RULE_01] Overflow sets control bit 7; it stays until software clears it.
// [RULE_02] No overflow flag while either serial clock select is set.
// [RULE_03] Trigger falling edge causing capture or reload sets bit 6 if enabled.
// [RULE_04] External flag requests timer interrupt when enabled; software clears it.
// [RULE_05] External flag raises no interrupt while down-count enable is set.
// [RULE_06] Bit 5 picks this timer's overflow as receive clock, else timer 1.
// [RULE_07] Bit 4 picks this timer's overflow as transmit clock, else timer 1.
// [RULE_08] Timer mode counts oscillator divided by 6 or by 12.
// [RULE_09] Counter mode steps on each falling edge of the count input.
// [RULE_10] Capture mode with trigger enable copies the counter on trigger edges.
// [RULE_11] Reload mode reloads on overflow and on enabled trigger edges.
// [RULE_12] Serial clock selects force reload on overflow, ignoring capture select.
// [RULE_13] Down-count enable makes the timer an up/down counter.
// [RULE_14] Counts only while run control bit 2 is set; else holds.
// [RULE_15] Trigger enable bit 3 clear blocks capture, reload and external flag.
`default_nettype none

package tm2_pkg;

   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'hc8;
   localparam logic [7:0] OFS_COUNT = 8'hcc;
   localparam logic [7:0] OFS_RELOAD = 8'hd0;
   localparam logic [7:0] OFS_CAPTURE = 8'hd4;
   localparam logic [7:0] OFS_MODE = 8'hd8;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hdc;
   localparam logic [7:0] OFS_IRQ_MASK = 8'he0;

   // -------------------------------------------------------------
   // Control register bit positions
   // -------------------------------------------------------------
   localparam int BIT_CRL = 0;
   localparam int BIT_TCS = 1;
   localparam int BIT_RUN = 2;
   localparam int BIT_EXEN = 3;
   localparam int BIT_TX_SEL = 4;
   localparam int BIT_RX_SEL = 5;
   localparam int BIT_EXF = 6;
   localparam int BIT_OVF = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // Mode register bits
   localparam int BIT_DOWN_EN = 0;
   localparam int BIT_SIX_CLK = 1;
   localparam int BIT_TIMER_IE = 2;
   localparam logic [2:0] MODE_RESET = 3'h0;

   // Interrupt status and mask bits
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_TRIGGER = 1;
   localparam int IRQ_BITS = 2;

   // -------------------------------------------------------------
   // Machine cycle lengths in oscillator clocks
   // -------------------------------------------------------------
   localparam logic [3:0] CLKS_SIX_MODE = 4'h6;
   localparam logic [3:0] CLKS_TWELVE_MODE = 4'hc;

   // AHB transfer types
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : tm2_pkg

`default_nettype wire

//--- core/tm2_fall_det.sv
/*
 * Falling edge detector for a group of pin inputs.
 * Assumes the inputs are already synchronous to clk.
 */
`default_nettype none

module tm2_fall_det #(
   parameter int N = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins and edges
   input wire logic [N-1:0] pin,
   output logic [N-1:0] fall
);

   logic [N-1:0] prev;

   // -------------------------------------------------------------
   // One history flop per pin
   // -------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               prev[i] <= 1'b1;
            else
               prev[i] <= pin[i];
         end
         assign fall[i] = prev[i] & ~pin[i];
      end
   endgenerate

endmodule // tm2_fall_det

`default_nettype wire

//--- core/tm2_ctrl.sv
/*
 * Third timer/counter with capture, auto-reload, up/down count and
 * serial baud clock selection, behind an AHB-Lite register slave.
 * Assumes clk is the device oscillator and that pins are synchronous.
 */
`default_nettype none

module tm2_ctrl #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Timer pins
   input wire logic count_pin,
   input wire logic external_trigger_pin,
   // Serial port baud clocks
   input wire logic timer1_overflow,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   // Interrupts
   output logic timer_irq_req,
   output logic irq
);

   import tm2_pkg::*;

   localparam logic [WIDTH-1:0] CNT_MAX = '1;

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic [7:0] third_timer_control;
   logic [2:0] mode;
   logic [WIDTH-1:0] counter;
   logic [WIDTH-1:0] reload;
   logic [WIDTH-1:0] capture;
   logic [IRQ_BITS-1:0] irq_status;
   logic [IRQ_BITS-1:0] irq_mask;
   logic [3:0] prescale;

   // Bus pipeline
   logic wr_pend;
   logic rd_pend;
   logic [7:0] dp_addr;
   logic bus_take;

   // Decoded writes and status read
   logic wr_control;
   logic wr_count;
   logic wr_reload;
   logic wr_mode;
   logic wr_mask;
   logic rd_status_done;

   // Fields
   logic capture_reload_select;
   logic timer_counter_select;
   logic run_control;
   logic external_trigger_enable;
   logic transmit_clock_select;
   logic receive_clock_select;
   logic down_count_enable;
   logic six_clock_mode;
   logic timer_int_enable;
   logic baud_mode;

   // Events
   logic [1:0] pin_fall;
   logic count_fall;
   logic trig_fall;
   logic mc_tick;
   logic step;
   logic dir_up;
   logic ovf_up;
   logic unf_down;
   logic ovf_event;
   logic capture_ev;
   logic reload_ev;
   logic overflow_flag_set;
   logic external_flag_set;
   logic [3:0] mc_last;
   logic [WIDTH-1:0] next_counter;
   logic [31:0] next_rdata;

   assign capture_reload_select = third_timer_control[BIT_CRL];
   assign timer_counter_select = third_timer_control[BIT_TCS];
   assign run_control = third_timer_control[BIT_RUN];
   assign external_trigger_enable = third_timer_control[BIT_EXEN];
   assign transmit_clock_select = third_timer_control[BIT_TX_SEL];
   assign receive_clock_select = third_timer_control[BIT_RX_SEL];
   assign down_count_enable = mode[BIT_DOWN_EN];
   assign six_clock_mode = mode[BIT_SIX_CLK];
   assign timer_int_enable = mode[BIT_TIMER_IE];
   assign baud_mode = receive_clock_select | transmit_clock_select;

   // -------------------------------------------------------------
   // Pin edges
   // -------------------------------------------------------------
   tm2_fall_det #(
      .N(2)
   ) u_fall (
      .clk(clk),
      .rst(rst),
      .pin({external_trigger_pin, count_pin}),
      .fall(pin_fall)
   );

   assign count_fall = pin_fall[0];
   assign trig_fall = pin_fall[1];

   // -------------------------------------------------------------
   // Machine cycle prescaler
   // -------------------------------------------------------------
   assign mc_last = (six_clock_mode ? CLKS_SIX_MODE : CLKS_TWELVE_MODE) - 4'h1;
   assign mc_tick = (prescale >= mc_last); // [RULE_08]

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prescale <= 4'h0;
      else if (mc_tick)
         prescale <= 4'h0;
      else
         prescale <= prescale + 4'h1;
   end

   // -------------------------------------------------------------
   // Count events
   // -------------------------------------------------------------
   // Stopped timer ignores both tick sources
   assign step = run_control & (timer_counter_select ? count_fall : mc_tick); // [RULE_14] [RULE_09] [RULE_08]

   // Up/down only in plain reload use; trigger pin level sets direction
   assign dir_up = ~down_count_enable | baud_mode | capture_reload_select
                   | external_trigger_pin; // [RULE_13]
   assign ovf_up = step & dir_up & (counter == CNT_MAX);
   assign unf_down = step & ~dir_up & (counter == reload); // [RULE_13]
   assign ovf_event = ovf_up | unf_down;

   // Trigger edges are dead with the enable clear or the counter in baud use
   assign capture_ev = trig_fall & external_trigger_enable & capture_reload_select
                       & ~baud_mode; // [RULE_10] [RULE_15]
   assign reload_ev = trig_fall & external_trigger_enable & ~capture_reload_select
                      & ~baud_mode & ~down_count_enable; // [RULE_11] [RULE_15]

   assign overflow_flag_set = ovf_event & ~baud_mode; // [RULE_01] [RULE_02]
   assign external_flag_set = capture_ev | reload_ev; // [RULE_03]

   always_comb
   begin
      next_counter = counter;
      if (reload_ev)
         next_counter = reload; // [RULE_11]
      else if (ovf_up)
      begin
         if (baud_mode || !capture_reload_select)
            next_counter = reload; // [RULE_11] [RULE_12]
         else
            next_counter = '0;
      end
      else if (unf_down)
         next_counter = CNT_MAX;
      else if (step)
      begin
         if (dir_up)
            next_counter = counter + 1'b1;
         else
            next_counter = counter - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         counter <= '0;
      else if (wr_count)
         counter <= hwdata[WIDTH-1:0];
      else
         counter <= next_counter;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         capture <= '0;
      else if (capture_ev)
         capture <= counter; // [RULE_10]
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         reload <= '0;
      else if (wr_reload)
         reload <= hwdata[WIDTH-1:0];
   end

   // -------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------
   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         third_timer_control <= CONTROL_RESET;
      else
      begin
         if (wr_control)
            third_timer_control <= hwdata[7:0];
         if (overflow_flag_set)
            third_timer_control[BIT_OVF] <= 1'b1; // [RULE_01]
         if (external_flag_set)
            third_timer_control[BIT_EXF] <= 1'b1; // [RULE_03] [RULE_04]
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mode <= MODE_RESET;
      else if (wr_mode)
         mode <= hwdata[2:0];
   end

   // -------------------------------------------------------------
   // Baud clock routing
   // -------------------------------------------------------------
   // Overflow pulses run to the port even while the flag is held off
   assign rx_baud_tick = receive_clock_select ? ovf_event : timer1_overflow; // [RULE_06]
   assign tx_baud_tick = transmit_clock_select ? ovf_event : timer1_overflow; // [RULE_07]

   // -------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------
   assign timer_irq_req = timer_int_enable
                          & (third_timer_control[BIT_OVF]
                             | (third_timer_control[BIT_EXF] & ~down_count_enable)); // [RULE_04] [RULE_05]

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_status <= '0;
      else
      begin
         if (rd_status_done)
            irq_status <= '0;
         if (ovf_event)
            irq_status[IRQ_OVERFLOW] <= 1'b1;
         if (external_flag_set)
            irq_status[IRQ_TRIGGER] <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_mask <= '0;
      else if (wr_mask)
         irq_mask <= hwdata[IRQ_BITS-1:0];
   end

   assign irq = |(irq_status & irq_mask);

   // -------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------
   // Reads take one wait state so that read data always come from a flop
   // and see a write made in the cycle before.
   assign bus_take = hsel & hready & (htrans == HTRANS_NONSEQ);
   assign hreadyout = ~rd_pend;
   assign hresp = 1'b0;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 8'h00;
      end
      else
      begin
         if (rd_pend)
            rd_pend <= 1'b0;
         else if (hready)
         begin
            wr_pend <= bus_take & hwrite;
            rd_pend <= bus_take & ~hwrite;
         end
         if (bus_take)
            dp_addr <= haddr[7:0];
      end
   end

   // Upper address bits are not decoded, so the register set
   // repeats every 256 bytes across the slave's window

   assign wr_control = wr_pend & (dp_addr == OFS_CONTROL);
   assign wr_count = wr_pend & (dp_addr == OFS_COUNT);
   assign wr_reload = wr_pend & (dp_addr == OFS_RELOAD);
   assign wr_mode = wr_pend & (dp_addr == OFS_MODE);
   assign wr_mask = wr_pend & (dp_addr == OFS_IRQ_MASK);
   assign rd_status_done = rd_pend & (dp_addr == OFS_IRQ_STATUS);

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (dp_addr)
         OFS_CONTROL: next_rdata[7:0] = third_timer_control;
         OFS_COUNT: next_rdata[WIDTH-1:0] = counter;
         OFS_RELOAD: next_rdata[WIDTH-1:0] = reload;
         OFS_CAPTURE: next_rdata[WIDTH-1:0] = capture;
         OFS_MODE: next_rdata[2:0] = mode;
         OFS_IRQ_STATUS: next_rdata[IRQ_BITS-1:0] = irq_status;
         OFS_IRQ_MASK: next_rdata[IRQ_BITS-1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (rd_pend)
         hrdata <= next_rdata;
   end

endmodule // tm2_ctrl

`default_nettype wire

//--- dv/tm2_ctrl_sva.sv
/* Port checker for tm2_ctrl: bus timing, baud clock choice, irq gate.
   Assumes hready is tied to hreadyout and only word transfers. */
`default_nettype none
module tm2_ctrl_sva
   import tm2_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Baud and interrupt
   input wire logic timer1_overflow,
   input wire logic rx_baud_tick,
   input wire logic tx_baud_tick,
   input wire logic timer_irq_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   logic take;
   logic wr_ph;
   logic [7:0] ad;
   logic [5:4] sel;
   logic [2:0] md;
   assign take = hsel && hready && htrans == HTRANS_NONSEQ;
   // Shadow of software-written select bits; hardware never touches them
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ph <= 1'b0;
         ad <= 8'h00;
         sel <= 2'h0;
         md <= 3'h0;
      end
      else
      begin
         wr_ph <= take && hwrite;
         ad <= haddr[7:0];
         if (wr_ph && ad == OFS_CONTROL)
            sel <= hwdata[5:4];
         if (wr_ph && ad == OFS_MODE)
            md <= hwdata[2:0];
      end
   end
   sequence s_read_taken;
      take && !hwrite;
   endsequence
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_wait: assert property (s_read_taken |=> s_one_wait)
      else $error("read without one wait state");
   a_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] < OFS_CONTROL |=> s_one_wait ##0 hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_rx_timer1: assert property (!sel[5] |-> rx_baud_tick == timer1_overflow)
      else $error("receive tick not from timer 1");
   a_tx_timer1: assert property (!sel[4] |-> tx_baud_tick == timer1_overflow)
      else $error("transmit tick not from timer 1");
   a_ticks_alike: assert property (&sel |-> rx_baud_tick == tx_baud_tick)
      else $error("baud ticks differ with same source");
   a_irq_disabled: assert property (!md[2] |-> !timer_irq_req)
      else $error("timer request while disabled");
endmodule // tm2_ctrl_sva

bind tm2_ctrl tm2_ctrl_sva #(.WIDTH(WIDTH)) u_tm2_ctrl_sva (.clk(clk), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer1_overflow(timer1_overflow),
   .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .timer_irq_req(timer_irq_req));
`default_nettype wire

//--- dv/tm2_pins.sv
/* Pin model: count and trigger pins idle high, fall on request.
   Assumes requests are one-clock pulses from the bench. */
`default_nettype none
module tm2_pins (
   // Clock
   input wire logic clk,
   // Requests
   input wire logic go_count,
   input wire logic go_trigger,
   // Timer pins
   output logic count_pin,
   output logic external_trigger_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_low = 2'h0;
   logic [1:0] trg_low = 2'h0;
   // Low for two clocks so one synchronous fall is always seen
   always @(posedge clk)
   begin
      cnt_low <= {cnt_low[0], go_count};
      trg_low <= {trg_low[0], go_trigger};
   end
   assign count_pin = ~|cnt_low;
   assign external_trigger_pin = ~|trg_low;
endmodule // tm2_pins
`default_nettype wire

//--- dv/tm2_ctrl_bench.sv
/* Self-checking bench for tm2_ctrl with AHB-Lite master tasks.
   Assumes the pin model and the bound port checker. */
`default_nettype none
module tm2_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tm2_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic t1_ovf = 1'b0;
   logic go_c = 1'b0;
   logic go_t = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] q;
   logic [15:0] rl;
   logic [15:0] cv;
   logic [15:0] cap;
   wire logic hreadyout, hresp, rxt, txt, treq, irq, cpin, tpin;
   wire logic [31:0] hrdata;
   int failures = 0;
   int n_tests = 0;
   int n_baud = 0;
   always #5 clk = ~clk;
   always @(posedge clk) t1_ovf <= ($urandom % 4) == 0;
   // Baud ticks counted mid-cycle, where they are settled
   always @(negedge clk) n_baud += (rxt === 1'b1) + (txt === 1'b1);
   tm2_ctrl u_tm2_ctrl (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .count_pin(cpin), .external_trigger_pin(tpin),
      .timer1_overflow(t1_ovf), .rx_baud_tick(rxt), .tx_baud_tick(txt), .timer_irq_req(treq), .irq(irq));
   tm2_pins u_tm2_pins (.clk(clk), .go_count(go_c), .go_trigger(go_t), .count_pin(cpin),
      .external_trigger_pin(tpin));
   task automatic give_verdict();
      $display("counts: %0d checks, %0d failures", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Ready is sampled at the falling edge so the rising edge never races
   task automatic wait_rdy();
      int n;
      logic r;
      n = 0;
      do
      begin
         @(negedge clk);
         r = hreadyout;
         q = hrdata;
         @(posedge clk);
         n++;
      end while (r !== 1'b1 && n < 20);
      if (r !== 1'b1)
      begin
         chk(0, 1, "bus timeout");
         give_verdict();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic pulse(input logic [1:0] p);
      go_t <= p[1];
      go_c <= p[0];
      @(posedge clk);
      go_t <= 1'b0;
      go_c <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic pin_chk(input logic [1:0] e);
      @(negedge clk);
      chk({irq, treq}, e, "irq outputs");
      @(posedge clk);
   endtask
   function automatic logic [7:0] exp_ctrl(input logic [7:0] v, input logic ovf);
      return v | ((ovf && !v[BIT_TX_SEL] && !v[BIT_RX_SEL]) ? 8'h80 : 8'h00) | ((!ovf && v[BIT_EXEN]) ? 8'h40 : 8'h00);
   endfunction
   initial
   begin
      int n;
      logic [7:0] v;
      void'($urandom(32'hfbc2270b));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, OFS_CONTROL, 0);
      chk(q, {24'h0, CONTROL_RESET}, "control reset");
      bus(0, 8'h40, 0);
      chk(q, 0, "unmapped read");
      $display("test reset done");
      for (int m = 0; m < 2; m++)
      begin
         bus(1, OFS_MODE, m * 2);
         bus(1, OFS_COUNT, 0);
         bus(1, OFS_CONTROL, 8'h04);
         repeat (m ? 120 : 240) @(posedge clk);
         bus(1, OFS_CONTROL, 0);
         bus(0, OFS_COUNT, 0);
         cv = q[15:0];
         chk(cv >= 20 && cv <= 21, 1, "tick rate");
         repeat (50) @(posedge clk);
         bus(0, OFS_COUNT, 0);
         chk(q, {16'h0, cv}, "held when stopped");
      end
      $display("test tick done");
      bus(1, OFS_COUNT, 0);
      bus(1, OFS_CONTROL, 8'h06);
      n = $urandom_range(9, 1);
      repeat (n) pulse(2'b01);
      bus(0, OFS_COUNT, 0);
      chk(q, n, "event count");
      rl = $urandom_range(16'hffef, 0);
      for (int k = 0; k < 3; k++)
      begin
         v = k == 0 ? 8'h06 : (k == 1 ? 8'h37 : 8'h07);
         bus(1, OFS_RELOAD, {16'h0, rl});
         bus(1, OFS_COUNT, 32'hffff);
         bus(1, OFS_CONTROL, v);
         n_baud = 0;
         pulse(2'b01);
         if (k == 1)
            chk(n_baud, 2, "baud ticks from overflow");
         bus(0, OFS_COUNT, 0);
         chk(q, {16'h0, k == 2 ? 16'h0 : rl}, "overflow reload");
         bus(0, OFS_CONTROL, 0);
         chk(q, exp_ctrl(v, 1), "overflow flag");
      end
      $display("test overflow done");
      bus(0, OFS_IRQ_STATUS, 0);
      cap = 16'h0;
      for (int k = 0; k < 3; k++)
      begin
         v = k == 0 ? 8'h0f : (k == 1 ? 8'h07 : 8'h0e);
         cv = $urandom;
         bus(1, OFS_CONTROL, v);
         bus(1, OFS_COUNT, {16'h0, cv});
         pulse(2'b10);
         if (k == 0)
            cap = cv;
         bus(0, OFS_CAPTURE, 0);
         chk(q, {16'h0, cap}, "capture");
         bus(0, OFS_COUNT, 0);
         chk(q, {16'h0, k == 2 ? rl : cv}, "trigger reload");
         bus(0, OFS_CONTROL, 0);
         chk(q, exp_ctrl(v, 0), "external flag");
      end
      $display("test trigger done");
      bus(1, OFS_IRQ_MASK, 0);
      pin_chk(2'b00);
      bus(1, OFS_IRQ_MASK, 2);
      pin_chk(2'b10);
      bus(1, OFS_MODE, 6);
      pin_chk(2'b11);
      bus(1, OFS_MODE, 7);
      pin_chk(2'b10);
      bus(0, OFS_IRQ_STATUS, 0);
      chk(q, 2, "status");
      pin_chk(2'b00);
      $display("test interrupt done");
      // Trigger pin held low with the count edge selects down counting
      bus(1, OFS_COUNT, {16'h0, rl + 16'h1});
      bus(1, OFS_CONTROL, 8'h0e);
      pulse(2'b11);
      bus(0, OFS_COUNT, 0);
      chk(q, {16'h0, rl}, "down count");
      pulse(2'b11);
      bus(0, OFS_COUNT, 0);
      chk(q, 32'hffff, "down underflow");
      bus(0, OFS_CONTROL, 0);
      chk(q, exp_ctrl(8'h0e, 1), "down flags");
      $display("test down count done");
      give_verdict();
   end
endmodule // tm2_ctrl_bench
`default_nettype wire
